// file: hw/sar_ctrl.sv
/*
 * Conversion control for a 10-bit successive-approximation converter:
 * start modes, cycle timing, selection buffering and result bytes.
 * Assumes the analog core returns its code on i_sar_code by the end
 * of each conversion and that trigger sources are event flags.
 */
`timescale 1ns/1ns
`include "sar_params.svh"

// Notes on behaviour
// - Selections apply only while enabled.
// - Result is a 10-bit code.
// - One bit picks supply or internal reference.
// - Right-aligned result unless left align set.
// - Low-byte read locks results until high read.
// - Done flag still sets on discarded result.
// - Start bit begins conversion, clears when done unless free running.
// - Mid-conversion channel change waits for the last cycle.
// - Trigger edge resets prescaler, starts conversion.
// - Held trigger or busy-time edge starts nothing.
// - Source flag must be cleared to retrigger.
// - Done-flag trigger means free running.
// - Start bit reads one whenever converting.
// - Prescaler divides, held reset while disabled.
// - Written start begins on next rising edge.
// - Conversion lasts 13 cycles, first 25.
// - Sample at 1.5 cycles, first at 13.5.
// - Result written, flag set, start cleared together (start stays set if free running).
// - Auto: sample at 2, length 13.5.
// - Free running: sample 2.5, length 14.
// - Selections tracked, locked while converting except in the last cycle.
module sar_ctrl
   import sar_pkg::*;
(
   input  wire logic                   i_clk,              // 20 MHz
   input  wire logic                   i_rst_n,            // Async, low
   input  wire logic                   i_converter_power_off, // Gated
   input  wire logic                   i_converter_enable, // Enable bit
   input  wire logic                   i_reference_select, // Ref choice
   input  wire logic [`SAR_CH_W-1:0]   i_channel_select,   // Channel
   input  wire logic                   i_left_align_result, // Align
   input  wire logic                   i_start_conversion_wr, // Write 1
   input  wire logic                   i_auto_trigger_enable, // Auto
   input  wire logic [`SAR_TSEL_W-1:0] i_trigger_source_select, // Src
   input  wire logic [`SAR_PSEL_W-1:0] i_prescale_select,  // Divider
   input  wire logic [`SAR_NSRC-1:0]   i_trigger_sources,  // Event flags
   input  wire logic                   i_done_flag_clr,    // Write 1 clr
   input  wire logic                   i_rd_low,           // Low read
   input  wire logic                   i_rd_high,          // High read
   input  wire logic [`SAR_RES_W-1:0]  i_sar_code,         // Core code
   output logic                        o_analog_enable,    // Core power
   output logic                        o_reference_select, // Applied ref
   output logic [`SAR_CH_W-1:0]        o_channel_select,   // Applied ch
   output logic                        o_sample_hold,      // Sample pulse
   output logic                        o_start_conversion, // Start bit
   output logic                        o_conversion_done_flag, // Flag
   output logic                        o_done_pulse,       // Irq event
   output logic [7:0]                  o_result_high_byte, // High byte
   output logic [7:0]                  o_result_low_byte   // Low byte
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      sar_state_e             st;
      sar_mode_e              mode;
      logic [`SAR_HALF_W-1:0] half;
      logic                   first;
      logic                   en;
      logic                   start;
      logic                   done;
      logic                   dpulse;
      logic                   lock;
      logic                   sh;
      logic                   trig_prev;
      logic                   ref_sel;
      logic [`SAR_CH_W-1:0]   ch;
      logic [`SAR_RES_W-1:0]  code;
      logic [7:0]             hi;
      logic [7:0]             lo;
   } sar_ctrl_s;

   sar_ctrl_s              s_r;
   sar_ctrl_s              s_nxt;
   logic                   en;
   logic                   rise;
   logic                   fall;
   logic                   half_tick;
   logic [`SAR_NSRC-1:0]   src_sync;
   logic                   trig_lvl;
   logic                   trig_edge;
   logic                   free_sel;
   logic                   trig_go;
   logic [`SAR_HALF_W-1:0] sh_pt;
   logic [`SAR_HALF_W-1:0] end_pt;
   logic [`SAR_HALF_W-1:0] half_inc;
   logic                   cmp;
   logic                   last_cyc;

   // ------------------------------------------------------------
   // Prescaler and trigger synchroniser
   // ------------------------------------------------------------
   // Power gating acts as a forced disable: nothing runs unpowered
   assign en = i_converter_enable && !i_converter_power_off;

   sar_presc u_presc (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_run     (en),
      .i_restart (trig_go),
      .i_sel     (i_prescale_select),
      .o_rise    (rise),
      .o_fall    (fall)
   );

   sar_sync #(
      .W (`SAR_NSRC)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_d     (i_trigger_sources),
      .o_q     (src_sync)
   );

   // Edge detect on the synchronised level: a level held high after
   // completion makes no new edge, so it cannot restart.
   assign trig_lvl  = src_sync[i_trigger_source_select];
   assign trig_edge = trig_lvl && !s_r.trig_prev;
   assign free_sel  = i_auto_trigger_enable &&
                      (i_trigger_source_select == `SAR_TSEL_FREE);
   assign trig_go   = en && (s_r.st == SAR_IDLE) &&
                      i_auto_trigger_enable && !free_sel &&
                      !i_start_conversion_wr && trig_edge;
   assign half_tick = rise || fall;

   // ------------------------------------------------------------
   // Timing points per mode
   // ------------------------------------------------------------
   always_comb begin
      case (s_r.mode)
         SAR_M_FIRST: begin
            sh_pt  = `SAR_FIRST_SH;
            end_pt = `SAR_FIRST_END;
         end
         SAR_M_NORM: begin
            sh_pt  = `SAR_NORM_SH;
            end_pt = `SAR_NORM_END;
         end
         SAR_M_AUTO: begin
            sh_pt  = `SAR_AUTO_SH;
            end_pt = `SAR_AUTO_END;
         end
         SAR_M_FREE: begin
            sh_pt  = `SAR_FREE_SH;
            end_pt = `SAR_FREE_END;
         end
         default: begin
            sh_pt  = `SAR_NORM_SH;
            end_pt = `SAR_NORM_END;
         end
      endcase
   end

   assign half_inc = s_r.half + 6'h01;
   assign cmp      = en && (s_r.st == SAR_CONV) && half_tick &&
                     (half_inc == end_pt);
   // Last converter clock cycle spans the final two half-cycles
   assign last_cyc = (s_r.half >= (end_pt - 6'h02));

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt           = s_r;
      s_nxt.sh        = 1'b0;
      s_nxt.dpulse    = 1'b0;
      s_nxt.en        = en;
      s_nxt.trig_prev = trig_lvl;

      if (i_done_flag_clr) begin
         s_nxt.done = 1'b0;
      end
      if (i_rd_low) begin
         s_nxt.lock = 1'b1;
      end
      if (i_rd_high) begin
         s_nxt.lock = 1'b0;
      end

      // Selections follow software only while enabled and not locked
      if (en && ((s_r.st != SAR_CONV) || last_cyc)) begin
         s_nxt.ch      = i_channel_select;
         s_nxt.ref_sel = i_reference_select;
      end

      if (!en) begin
         s_nxt.st    = SAR_IDLE;
         s_nxt.start = 1'b0;
         s_nxt.first = 1'b1;
         s_nxt.half  = '0;
      end else begin
         case (s_r.st)
            SAR_IDLE: begin
               if (i_start_conversion_wr) begin
                  s_nxt.start = 1'b1;
                  s_nxt.st    = SAR_PEND;
                  s_nxt.mode  = s_r.first ? SAR_M_FIRST : SAR_M_NORM;
               end else if (trig_go) begin
                  s_nxt.start = 1'b1;
                  s_nxt.st    = SAR_CONV;
                  s_nxt.half  = '0;
                  s_nxt.mode  = s_r.first ? SAR_M_FIRST : SAR_M_AUTO;
               end
            end
            SAR_PEND: begin
               if (rise) begin
                  s_nxt.st   = SAR_CONV;
                  s_nxt.half = '0;
               end
            end
            SAR_CONV: begin
               if (half_tick) begin
                  s_nxt.half = half_inc;
                  if (half_inc == sh_pt) begin
                     s_nxt.sh = 1'b1;
                  end
               end
               if (cmp) begin
                  s_nxt.done   = 1'b1;
                  s_nxt.dpulse = 1'b1;
                  s_nxt.first  = 1'b0;
                  if (!s_r.lock) begin
                     s_nxt.code = i_sar_code;
                  end
                  if (free_sel) begin
                     s_nxt.half = '0;
                     s_nxt.mode = SAR_M_FREE;
                  end else begin
                     s_nxt.st    = SAR_IDLE;
                     s_nxt.start = 1'b0;
                  end
               end
            end
            default: begin
               s_nxt.st = SAR_IDLE;
            end
         endcase
      end

      if (i_left_align_result) begin
         s_nxt.hi = s_nxt.code[9:2];
         s_nxt.lo = {s_nxt.code[1:0], 6'h00};
      end else begin
         s_nxt.hi = {6'h00, s_nxt.code[9:8]};
         s_nxt.lo = s_nxt.code[7:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r       <= '0;
         s_r.st    <= SAR_IDLE;
         s_r.mode  <= SAR_M_FIRST;
         s_r.first <= 1'b1;
         s_r.ch    <= `SAR_CH_RST;
         s_r.code  <= `SAR_CODE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_analog_enable        = s_r.en;
   assign o_reference_select     = s_r.ref_sel;
   assign o_channel_select       = s_r.ch;
   assign o_sample_hold          = s_r.sh;
   assign o_start_conversion     = s_r.start;
   assign o_conversion_done_flag = s_r.done;
   assign o_done_pulse           = s_r.dpulse;
   assign o_result_high_byte     = s_r.hi;
   assign o_result_low_byte      = s_r.lo;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   lock_hold_a: assert property (
      (s_r.lock && !i_rd_high) |=> $stable(s_r.code))
      else $error("result changed while locked");

   lost_flag_a: assert property (
      (cmp && s_r.lock && !i_done_flag_clr) |=> s_r.done)
      else $error("done flag missing on discarded result");

   single_clear_a: assert property (
      (cmp && !free_sel) |=> (!s_r.start && s_r.done &&
                              s_r.st == SAR_IDLE))
      else $error("single completion did not clear start");

   free_restart_a: assert property (
      (cmp && free_sel) |=> (s_r.start && s_r.st == SAR_CONV &&
                             s_r.half == 6'h00 &&
                             s_r.mode == SAR_M_FREE))
      else $error("free running did not restart");

   disable_idle_a: assert property (
      !en |=> (s_r.st == SAR_IDLE && !s_r.start && s_r.first))
      else $error("converter active while disabled");

   pend_rise_a: assert property (
      (s_r.st == SAR_PEND && en && !rise) |=> s_r.st == SAR_PEND)
      else $error("conversion began off the rising edge");

   busy_start_a: assert property (
      (s_r.st != SAR_IDLE) |-> s_r.start)
      else $error("start bit low during conversion");

   first_sample_a: assert property (
      (s_r.sh && s_r.mode == SAR_M_FIRST) |-> s_r.half == 6'h1b)
      else $error("first conversion sampled at wrong time");

   norm_sample_a: assert property (
      (s_r.sh && s_r.mode == SAR_M_NORM) |-> s_r.half == 6'h03)
      else $error("normal conversion sampled at wrong time");

   chan_lock_a: assert property (
      (s_r.st == SAR_CONV && !last_cyc && en) |=> $stable(s_r.ch))
      else $error("channel changed mid conversion");

   edge_ignore_a: assert property (
      (s_r.st == SAR_CONV && en && !cmp) |=> s_r.st == SAR_CONV)
      else $error("conversion disturbed before completion");

   norm_length_a: assert property (
      (cmp && s_r.mode == SAR_M_NORM) |-> s_r.half == 6'h19)
      else $error("normal conversion length wrong");

endmodule

// file: common/sar_params.svh
/*
 * Timing counts, widths and encodings for the conversion control block.
 * Assumes the includer works on a single system clock.
 */
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define SAR_RES_W       10
`define SAR_HALF_W      6
`define SAR_CH_W        4
`define SAR_TSEL_W      3
`define SAR_PSEL_W      3
`define SAR_PSC_W       7
`define SAR_NSRC        8

// ------------------------------------------------------------
// Converter clock half-cycles from conversion start
// ------------------------------------------------------------
`define SAR_FIRST_SH    6'h1b
`define SAR_FIRST_END   6'h32
`define SAR_NORM_SH     6'h03
`define SAR_NORM_END    6'h1a
`define SAR_AUTO_SH     6'h04
`define SAR_AUTO_END    6'h1b
`define SAR_FREE_SH     6'h05
`define SAR_FREE_END    6'h1c

// ------------------------------------------------------------
// Encodings and reset values
// ------------------------------------------------------------
`define SAR_TSEL_FREE   3'h0
`define SAR_CH_RST      4'h0
`define SAR_CODE_RST    10'h000

`endif

// file: common/sar_pkg.sv
/*
 * Types shared by the conversion control block.
 * Assumes the timing counts come from sar_params.svh.
 */
package sar_pkg;

   // Gray order along idle -> pending -> converting
   typedef enum logic [1:0] {
      SAR_IDLE = 2'h0,
      SAR_PEND = 2'h1,
      SAR_CONV = 2'h3
   } sar_state_e;

   typedef enum logic [1:0] {
      SAR_M_FIRST = 2'h0,
      SAR_M_NORM  = 2'h1,
      SAR_M_AUTO  = 2'h3,
      SAR_M_FREE  = 2'h2
   } sar_mode_e;

endpackage

// file: hw/sar_sync.sv
/*
 * Two-stage synchroniser for the auto-trigger source levels.
 * Assumes the sources may change at any time relative to i_clk.
 */
`timescale 1ns/1ns
module sar_sync
   import sar_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         i_clk,    // System clock
   input  wire logic         i_rst_n,  // Async reset, active low
   input  wire logic [W-1:0] i_d,      // Raw source levels
   output logic      [W-1:0] o_q       // Synchronised levels
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sar_sync_s;

   sar_sync_s s_r;
   sar_sync_s s_nxt;

   always_comb begin
      s_nxt    = s_r;
      s_nxt.s1 = i_d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_q = s_r.s2;

endmodule

// file: hw/sar_presc.sv
/*
 * Converter clock prescaler: rise and fall enable pulses.
 * Assumes i_run low holds it in reset and i_restart realigns it.
 */
`timescale 1ns/1ns
`include "sar_params.svh"
module sar_presc
   import sar_pkg::*;
(
   input  wire logic                   i_clk,     // System clock
   input  wire logic                   i_rst_n,   // Async reset, low
   input  wire logic                   i_run,     // Count while high
   input  wire logic                   i_restart, // Realign to zero
   input  wire logic [`SAR_PSEL_W-1:0] i_sel,     // Division select
   output logic                        o_rise,    // Rising edge pulse
   output logic                        o_fall     // Falling edge pulse
);

   typedef struct packed {
      logic [`SAR_PSC_W-1:0] cnt;
      logic                  rise;
      logic                  fall;
   } sar_presc_s;

   sar_presc_s            s_r;
   sar_presc_s            s_nxt;
   logic [`SAR_PSC_W-1:0] top;
   logic [`SAR_PSC_W-1:0] half;

   // Ratio is 2^sel with the lowest select also giving two
   always_comb begin
      top  = (i_sel == 3'h0) ? 7'h01 : 7'((8'h01 << i_sel) - 8'h01);
      half = 7'(top >> 1);
   end

   always_comb begin
      s_nxt      = s_r;
      s_nxt.rise = 1'b0;
      s_nxt.fall = 1'b0;
      if (!i_run || i_restart) begin
         s_nxt.cnt = '0;
      end else begin
         if (s_r.cnt == top) begin
            s_nxt.cnt  = '0;
            s_nxt.rise = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 7'h01;
         end
         if (s_r.cnt == half) begin
            s_nxt.fall = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rise = s_r.rise;
   assign o_fall = s_r.fall;

endmodule

// file: dv/sar_conversion_control_test.sv
/*
 * Self-checking bench for sar_ctrl: start modes, cycle timing,
 * selection buffering, result alignment and the paired-read lock.
 * Assumes sar_ctrl alone; the bench stands in for the analog core.
 */
`timescale 1ns/1ns
`include "sar_params.svh"
module sar_conversion_control_test
   import sar_pkg::*;
();
   logic                   i_clk, i_rst_n, i_converter_power_off;
   logic                   i_converter_enable, i_reference_select;
   logic [`SAR_CH_W-1:0]   i_channel_select, was;
   logic                   i_left_align_result, i_start_conversion_wr;
   logic                   i_auto_trigger_enable, i_done_flag_clr;
   logic [`SAR_TSEL_W-1:0] i_trigger_source_select;
   logic [`SAR_PSEL_W-1:0] i_prescale_select;
   logic [`SAR_NSRC-1:0]   i_trigger_sources;
   logic                   i_rd_low, i_rd_high;
   logic [`SAR_RES_W-1:0]  i_sar_code, code, old;
   logic                   o_analog_enable, o_reference_select;
   logic [`SAR_CH_W-1:0]   o_channel_select;
   logic                   o_sample_hold, o_start_conversion;
   logic                   o_conversion_done_flag, o_done_pulse;
   logic [7:0]             o_result_high_byte, o_result_low_byte;
   int n_errors, total_checks, cyc, sh_cyc, done_cyc, n_dn;
   int r, len, g0, l0, lat, tt, n0;

   initial i_clk = 1'b0;
   always #25 i_clk = ~i_clk;

   sar_ctrl sar_ctrl_i (
      .i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_converter_power_off(i_converter_power_off),
      .i_converter_enable(i_converter_enable),
      .i_reference_select(i_reference_select),
      .i_channel_select(i_channel_select),
      .i_left_align_result(i_left_align_result),
      .i_start_conversion_wr(i_start_conversion_wr),
      .i_auto_trigger_enable(i_auto_trigger_enable),
      .i_trigger_source_select(i_trigger_source_select),
      .i_prescale_select(i_prescale_select),
      .i_trigger_sources(i_trigger_sources),
      .i_done_flag_clr(i_done_flag_clr), .i_rd_low(i_rd_low),
      .i_rd_high(i_rd_high), .i_sar_code(i_sar_code),
      .o_analog_enable(o_analog_enable),
      .o_reference_select(o_reference_select),
      .o_channel_select(o_channel_select),
      .o_sample_hold(o_sample_hold),
      .o_start_conversion(o_start_conversion),
      .o_conversion_done_flag(o_conversion_done_flag),
      .o_done_pulse(o_done_pulse),
      .o_result_high_byte(o_result_high_byte),
      .o_result_low_byte(o_result_low_byte)
   );

   // -------------------------------------------------------------
   // Event monitor
   // -------------------------------------------------------------
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_sample_hold === 1'b1) begin
         sh_cyc <= cyc;
      end
      if (o_done_pulse === 1'b1) begin
         done_cyc <= cyc;
         n_dn <= n_dn + 1;
      end
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [15:0] aligned(input logic [9:0] c,
                                           input logic left);
      return left ? {c, 6'h00} : {6'h00, c};
   endfunction

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // Order: start, low read, high read, flag clear
   task automatic pulse(input logic [3:0] w);
      {i_start_conversion_wr, i_rd_low, i_rd_high, i_done_flag_clr} <= w;
      step(1);
      {i_start_conversion_wr, i_rd_low, i_rd_high, i_done_flag_clr} <= 4'h0;
      // Idle edge so a following pulse never re-drives in this time step
      step(1);
   endtask

   task automatic wait_dn(input int want, input int lim);
      int k;
      k = 0;
      while (n_dn < want && k < lim) begin
         step(1);
         k++;
      end
      if (n_dn < want) begin
         n_errors++;
         $display("CHECK FAILED done wait expected %0d seen %0d", want, n_dn);
         print_verdict();
      end
   endtask

   // Single start; a second write and a channel change land mid-run
   task automatic single(input logic [3:0] ch);
      int t0;
      int m0;
      t0 = cyc;
      m0 = n_dn;
      code = 10'($urandom);
      i_sar_code <= code;
      pulse(4'h8);
      step(4);
      check("busy", o_start_conversion, 1);
      was = o_channel_select;
      pulse(4'h8);
      i_channel_select <= ch;
      step(3);
      check("ch held", o_channel_select, was);
      wait_dn(m0 + 1, 40 * r);
      len = done_cyc - t0;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {i_converter_enable, i_reference_select, i_left_align_result} = 0;
      {i_start_conversion_wr, i_auto_trigger_enable, i_rd_low} = 0;
      {i_rd_high, i_done_flag_clr, i_trigger_sources} = 0;
      {i_channel_select, i_trigger_source_select, i_sar_code} = 0;
      i_prescale_select = 3'h2;
      i_converter_power_off = 1'b1;
      i_rst_n = 1'b0;
      code = 10'($urandom(92));
      r = 4;
      step(16);
      i_rst_n <= 1'b1;
      step(2);
      check("start rst", o_start_conversion, 0);
      check("bytes rst", {o_result_high_byte, o_result_low_byte}, 0);
      i_channel_select <= 4'h5;
      i_reference_select <= 1'b1;
      i_converter_enable <= 1'b1;
      step(3);
      check("gated", o_analog_enable, 0);
      check("ch frozen", o_channel_select, 4'h0);
      i_converter_power_off <= 1'b0;
      step(3);
      check("powered", o_analog_enable, 1);
      check("sel on", {o_reference_select, o_channel_select}, 5'h15);
      single(4'h5);
      check("first len", len >= 25*r && len <= 26*r + 4, 1);
      g0 = done_cyc - sh_cyc;
      check("first sh", g0 >= 23*r/2 && g0 <= 23*r/2 + 2, 1);
      check("start clr", o_start_conversion, 0);
      check("flag", o_conversion_done_flag, 1);
      check("right", {o_result_high_byte, o_result_low_byte},
            aligned(code, 1'b0));
      i_left_align_result <= 1'b1;
      step(3);
      check("left", {o_result_high_byte, o_result_low_byte},
            aligned(code, 1'b1));
      i_left_align_result <= 1'b0;
      single(4'h9);
      check("norm len", len >= 13*r && len <= 14*r + 4, 1);
      check("norm sh", done_cyc - sh_cyc, g0);
      check("ch new", o_channel_select, 4'h9);
      n0 = n_dn;
      step(30 * r);
      check("no extra", n_dn, n0);
      // Locked completion keeps the old pair but still flags
      old = code;
      pulse(4'h1);
      pulse(4'h4);
      check("flag clr", o_conversion_done_flag, 0);
      single(4'h9);
      check("lost flag", o_conversion_done_flag, 1);
      check("locked", {o_result_high_byte, o_result_low_byte},
            aligned(old, 1'b0));
      pulse(4'h2);
      single(4'h9);
      check("unlocked", {o_result_high_byte, o_result_low_byte},
            aligned(code, 1'b0));
      // Every event source, at a random prescaler phase
      i_auto_trigger_enable <= 1'b1;
      for (int s = 1; s < 8; s++) begin
         i_trigger_source_select <= 3'(s);
         step(2 + $urandom % 8);
         n0 = n_dn;
         tt = cyc;
         i_trigger_sources[s] <= 1'b1;
         step(10);
         i_trigger_sources[s] <= 1'b0;
         step(4);
         i_trigger_sources[s] <= 1'b1;
         wait_dn(n0 + 1, 40 * r);
         lat = sh_cyc - tt;
         check("trig lat", lat >= 2*r + 2 && lat <= 2*r + 7, 1);
         if (s == 1) begin
            l0 = lat;
         end
         check("trig same", lat, l0);
         check("auto sh", done_cyc - sh_cyc, g0);
         step(30 * r);
         check("held trig", n_dn, n0 + 1);
         i_trigger_sources[s] <= 1'b0;
         step(3);
      end
      single(4'h9);
      // Free running over every divider setting
      for (int p = 0; p < 8; p++) begin
         i_converter_enable <= 1'b0;
         step(2);
         check("abort", o_start_conversion, 0);
         r = (p == 0) ? 2 : 1 << p;
         // Only /128 keeps the converter clock in range at 20 MHz;
         // faster ratios are used to shorten the run, not for accuracy
         i_prescale_select <= 3'(p);
         i_trigger_source_select <= `SAR_TSEL_FREE;
         i_converter_enable <= 1'b1;
         n0 = n_dn;
         step(4 * r);
         check("free idle", n_dn, n0);
         pulse(4'h8);
         wait_dn(n0 + 2, 40 * r + 10);
         tt = done_cyc;
         wait_dn(n0 + 3, 20 * r);
         check("free period", done_cyc - tt, 14 * r);
         check("free busy", o_start_conversion, 1);
      end
      i_converter_enable <= 1'b0;
      step(3);
      check("off", o_start_conversion, 0);
      print_verdict();
   end
endmodule
